/* verilog/spag_pkg.sv */
/*
 * Constants, register map and state type for the self-programming
 * access guard. Assumes a flash of 64K words with 128-word pages.
 */
package spag_pkg;

	// ==========================================================
	// Flash geometry
	localparam int unsigned BYTE_AW = 17;
	localparam int unsigned WORD_AW = 16;
	localparam int unsigned PAGE_IDX_W = 7;
	localparam int unsigned PAGE_W = WORD_AW - PAGE_IDX_W;
	// First word of the halting region; everything below it is the
	// concurrent-read region.
	localparam logic [15:0] HALT_START = 16'hE000;
	// Boot start per boot size fuse code, indexed by the code.
	localparam logic [15:0] BOOT_START_0 = 16'hF000;
	localparam logic [15:0] BOOT_START_1 = 16'hF800;
	localparam logic [15:0] BOOT_START_2 = 16'hFC00;
	localparam logic [15:0] BOOT_START_3 = 16'hFE00;
	localparam logic [15:0] APP_RESET = 16'h0000;

	// ==========================================================
	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ZLO = 8'h04;
	localparam logic [7:0] OFS_ZHI = 8'h08;
	localparam logic [7:0] OFS_ZEXT = 8'h0C;
	localparam logic [7:0] OFS_LOCK = 8'h10;
	localparam logic [7:0] OFS_FUSE = 8'h14;

	// Control register fields.
	localparam int unsigned CTRL_BUSY = 0;
	localparam int unsigned CTRL_RRE = 1;
	localparam int unsigned CTRL_OP = 2;
	localparam int unsigned CTRL_HALT = 3;
	localparam int unsigned CTRL_REFUSED = 4;

	// Lock register fields and reset value.
	localparam int unsigned LK_GEN_LO = 0;
	localparam int unsigned LK_APP_LO = 2;
	localparam int unsigned LK_BOOT_LO = 4;
	localparam logic [5:0] LOCK_RESET = 6'h3F;
	localparam logic [1:0] GEN_WRITE_LOCK = 2'h2;
	localparam logic [1:0] GEN_RW_LOCK = 2'h0;
	localparam logic [1:0] PAIR_NO_WRITE = 2'h2;
	localparam logic [1:0] PAIR_FULL = 2'h0;

	// Store-program-memory operation kinds.
	localparam logic [1:0] OP_LOAD = 2'h0;
	localparam logic [1:0] OP_ERASE = 2'h1;
	localparam logic [1:0] OP_WRITE = 2'h2;
	localparam logic [1:0] OP_LOCKSET = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONC,
		ST_HALT
	} spag_state_e;

endpackage : spag_pkg

/* verilog/spag_guard.sv */
/*
 * Self-programming access guard: region arbitration, lock checks,
 * reset vector and flash address forming, with a classic Wishbone
 * slave. Assumes the CPU pulses its requests for one cycle and the
 * flash array pulses flash_done_i when an erase or write finishes.
 */
// What this block does
// - Concurrent-region erase/write keeps CPU running; halting region stays readable.
// - Halting-region erase/write stalls the CPU for the whole operation.
// - Concurrent region unreadable during programming; software must not touch it.
// - Operation classified by target page address, not by executing region.
// - Region-busy bit reads one while concurrent region is blocked.
// - Boot section always lies wholly inside the halting region.
// - Boot lock bits only program by software; only chip erase or reset unprograms.
// - General lock mode 2 refuses store-program-memory flash programming.
// - General lock mode 0 refuses program loads and stores.
// - Application pair 10 blocks stores to application section, reads allowed.
// - Application pair 00/01 block boot-executed loads; 00 also blocks stores.
// - Application pair 00/01, boot vectors: interrupts off in application code.
// - Boot pair 10 blocks stores to boot section, reads allowed.
// - Boot pair 00/01 block application-executed loads; 00 also blocks stores.
// - Boot pair 00/01, application vectors: interrupts off in boot code.
// - Boot-reset fuse 1 starts at word 0, 0 at boot start.
// - CPU has no path to alter fuses.
// - Flash address from low, high and extension pointer bytes.
// - Low bits index word in page, high bits page; bit 0 selects byte.
// - Target page is latched when an erase or write starts.
`timescale 1ns/10ps
module spag_guard
	import spag_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [7:0]        adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	input  wire logic [WORD_AW-1:0] pc_i,
	input  wire logic              vec_in_boot_i,
	input  wire logic              store_req_i,
	input  wire logic [1:0]        store_kind_i,
	input  wire logic [5:0]        store_data_i,
	input  wire logic              load_req_i,
	input  wire logic              flash_done_i,
	input  wire logic              chip_erase_i,
	input  wire logic              boot_reset_fuse_i,
	input  wire logic [1:0]        boot_size_fuses_i,
	output logic                   cpu_stall_o,
	output logic                   region_busy_o,
	output logic                   irq_disable_o,
	output logic                   load_grant_o,
	output logic                   load_deny_o,
	output logic                   store_refused_o,
	output logic                   flash_start_o,
	output logic      [1:0]        flash_op_o,
	output logic      [PAGE_W-1:0] flash_page_o,
	output logic      [PAGE_IDX_W-1:0] buf_word_o,
	output logic                   byte_select_bit_o,
	output logic      [WORD_AW-1:0] reset_vector_o
);

	// ==========================================================
	// State
	typedef struct packed {
		logic              ack;
		logic [31:0]       dat;
		logic [7:0]        zlo;
		logic [7:0]        zhi;
		logic [7:0]        zext;
		logic [5:0]        lock;
		logic              busy;
		logic              refused_st;
		spag_state_e       st;
		logic [1:0]        op;
		logic [PAGE_W-1:0] page;
		logic              start;
		logic              refused;
		logic              grant;
		logic              deny;
	} spag_regs_s;

	spag_regs_s r_q;
	spag_regs_s r_d;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] boot_start(input logic [1:0] sz);
		logic [15:0] s;
		case (sz)
			2'h0: s = BOOT_START_0;
			2'h1: s = BOOT_START_1;
			2'h2: s = BOOT_START_2;
			default: s = BOOT_START_3;
		endcase
		// A boot section never reaches below the halting region.
		return (s < HALT_START) ? HALT_START : s;
	endfunction : boot_start

	function automatic logic in_boot(input logic [15:0] w,
		input logic [15:0] bs);
		return w >= bs;
	endfunction : in_boot

	// ==========================================================
	// Address forming
	logic [23:0]        z_full;
	logic [BYTE_AW-1:0] z_byte;
	logic [WORD_AW-1:0] z_word;
	logic [15:0]        bstart;
	logic               tgt_boot;
	logic               exe_boot;
	logic               tgt_halt;
	logic [1:0]         gen;
	logic [1:0]         app;
	logic [1:0]         boot;

	// The extension byte only contributes its low bit in this size.
	assign z_full = {r_q.zext, r_q.zhi, r_q.zlo};
	assign z_byte = z_full[BYTE_AW-1:0];
	assign z_word = z_byte[BYTE_AW-1:1];
	assign bstart = boot_start(boot_size_fuses_i);
	assign tgt_boot = in_boot(z_word, bstart);
	assign exe_boot = in_boot(pc_i, bstart);
	assign tgt_halt = z_word >= HALT_START;
	assign gen = r_q.lock[LK_GEN_LO +: 2];
	assign app = r_q.lock[LK_APP_LO +: 2];
	assign boot = r_q.lock[LK_BOOT_LO +: 2];

	// ==========================================================
	// Lock decisions
	logic prog_kind;
	logic store_block;
	logic load_block;

	assign prog_kind = (store_kind_i == OP_ERASE) ||
		(store_kind_i == OP_WRITE);

	always_comb begin
		store_block = 1'b0;
		if (gen == GEN_WRITE_LOCK) begin
			store_block = 1'b1;
		end
		if (gen == GEN_RW_LOCK) begin
			store_block = 1'b1;
		end
		if (!tgt_boot && (app == PAIR_NO_WRITE)) begin
			store_block = 1'b1;
		end
		if (!tgt_boot && (app == PAIR_FULL)) begin
			store_block = 1'b1;
		end
		if (tgt_boot && (boot == PAIR_NO_WRITE)) begin
			store_block = 1'b1;
		end
		if (tgt_boot && (boot == PAIR_FULL)) begin
			store_block = 1'b1;
		end
	end

	// Loads compare the executing section with the addressed one.
	always_comb begin
		load_block = 1'b0;
		if (gen == GEN_RW_LOCK) begin
			load_block = 1'b1;
		end
		if (exe_boot && !tgt_boot && !app[1]) begin
			load_block = 1'b1;
		end
		if (!exe_boot && tgt_boot && !boot[1]) begin
			load_block = 1'b1;
		end
		// The concurrent region answers nothing while blocked.
		if (r_q.busy && !tgt_halt) begin
			load_block = 1'b1;
		end
	end

	// ==========================================================
	// Bus decode
	logic       bus_req;
	logic       wr;
	logic [31:0] rd_val;

	assign bus_req = cyc_i && stb_i && !r_q.ack;
	assign wr = bus_req && we_i && sel_i[0];

	always_comb begin
		rd_val = 32'h0000_0000;
		case (adr_i)
			OFS_CTRL: begin
				rd_val[CTRL_BUSY] = r_q.busy;
				rd_val[CTRL_OP] = r_q.st != ST_IDLE;
				rd_val[CTRL_HALT] = r_q.st == ST_HALT;
				rd_val[CTRL_REFUSED] = r_q.refused_st;
			end
			OFS_ZLO: rd_val[7:0] = r_q.zlo;
			OFS_ZHI: rd_val[7:0] = r_q.zhi;
			OFS_ZEXT: rd_val[7:0] = r_q.zext;
			OFS_LOCK: rd_val[5:0] = r_q.lock;
			OFS_FUSE: rd_val[2:0] = {boot_size_fuses_i,
				boot_reset_fuse_i};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// Next state
	logic store_go;

	assign store_go = store_req_i && prog_kind && (r_q.st == ST_IDLE) &&
		!store_block;

	always_comb begin
		r_d = r_q;
		r_d.ack = bus_req;
		r_d.dat = bus_req ? rd_val : r_q.dat;
		r_d.start = 1'b0;
		r_d.refused = 1'b0;
		r_d.grant = 1'b0;
		r_d.deny = 1'b0;
		if (wr) begin
			case (adr_i)
				OFS_ZLO: r_d.zlo = dat_i[7:0];
				OFS_ZHI: r_d.zhi = dat_i[7:0];
				OFS_ZEXT: r_d.zext = dat_i[7:0];
				// Software can only program lock bits, never erase.
				OFS_LOCK: r_d.lock = r_q.lock & dat_i[5:0];
				OFS_CTRL: begin
					if (dat_i[CTRL_REFUSED]) begin
						r_d.refused_st = 1'b0;
					end
					if (dat_i[CTRL_RRE] && r_q.st == ST_IDLE) begin
						r_d.busy = 1'b0;
					end
				end
				// The fuse word is read only.
				default: r_d.lock = r_d.lock;
			endcase
		end
		if (store_req_i && store_kind_i == OP_LOCKSET &&
			r_q.st == ST_IDLE) begin
			r_d.lock = r_d.lock & store_data_i;
		end
		if (chip_erase_i) begin
			r_d.lock = LOCK_RESET;
		end
		if (load_req_i) begin
			r_d.grant = !load_block;
			r_d.deny = load_block;
		end
		case (r_q.st)
			ST_IDLE: begin
				if (store_go) begin
					r_d.page = z_word[WORD_AW-1:PAGE_IDX_W];
					r_d.op = store_kind_i;
					r_d.start = 1'b1;
					r_d.busy = 1'b1;
					r_d.st = tgt_halt ? ST_HALT : ST_CONC;
				end
			end
			ST_CONC, ST_HALT: begin
				if (flash_done_i) begin
					r_d.st = ST_IDLE;
				end
			end
			default: r_d.st = ST_IDLE;
		endcase
		// A refused or mistimed store ends without touching flash.
		if (store_req_i && prog_kind && !store_go) begin
			r_d.refused = 1'b1;
			r_d.refused_st = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_q <= '0;
			r_q.lock <= LOCK_RESET;
			r_q.st <= ST_IDLE;
		end else begin
			r_q <= r_d;
		end
	end

	// ==========================================================
	// Outputs
	assign dat_o = r_q.dat;
	assign ack_o = r_q.ack;
	assign cpu_stall_o = r_q.st == ST_HALT;
	assign region_busy_o = r_q.busy;
	assign load_grant_o = r_q.grant;
	assign load_deny_o = r_q.deny;
	assign store_refused_o = r_q.refused;
	assign flash_start_o = r_q.start;
	assign flash_op_o = r_q.op;
	assign flash_page_o = r_q.page;
	assign buf_word_o = z_word[PAGE_IDX_W-1:0];
	assign byte_select_bit_o = z_byte[0];
	assign irq_disable_o = (!app[1] && vec_in_boot_i && !exe_boot) ||
		(!boot[1] && !vec_in_boot_i && exe_boot);
	assign reset_vector_o = boot_reset_fuse_i ? APP_RESET : bstart;

	// ==========================================================
	// Checks
	a_halt_stall: assert property (@(posedge clk_i) disable iff (rst_i)
		store_go && tgt_halt |=> cpu_stall_o && region_busy_o)
		else $error("halting-region operation did not stall");

	a_conc_run: assert property (@(posedge clk_i) disable iff (rst_i)
		store_go && !tgt_halt |=> !cpu_stall_o && region_busy_o)
		else $error("concurrent-region operation stalled the CPU");

	a_stall_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		cpu_stall_o && !flash_done_i |=> cpu_stall_o)
		else $error("stall released before flash done");

	a_busy_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		region_busy_o && !(wr && adr_i == OFS_CTRL && dat_i[CTRL_RRE])
		|=> region_busy_o)
		else $error("region busy dropped without release");

	a_page_latch: assert property (@(posedge clk_i) disable iff (rst_i)
		flash_start_o ##1 (r_q.st != ST_IDLE) |-> $stable(flash_page_o))
		else $error("latched page changed during operation");

	a_write_lock: assert property (@(posedge clk_i) disable iff (rst_i)
		store_req_i && prog_kind && gen == GEN_WRITE_LOCK
		|=> store_refused_o && !flash_start_o)
		else $error("store accepted under write lock");

	a_rw_lock: assert property (@(posedge clk_i) disable iff (rst_i)
		load_req_i && gen == GEN_RW_LOCK |=> load_deny_o && !load_grant_o)
		else $error("load granted under read/write lock");

	a_app_nowr: assert property (@(posedge clk_i) disable iff (rst_i)
		store_req_i && prog_kind && !tgt_boot && app == PAIR_NO_WRITE
		|=> !flash_start_o)
		else $error("application store passed pair 10");

	a_boot_nowr: assert property (@(posedge clk_i) disable iff (rst_i)
		store_req_i && prog_kind && tgt_boot && boot == PAIR_NO_WRITE
		|=> !flash_start_o)
		else $error("boot store passed pair 10");

	a_app_read: assert property (@(posedge clk_i) disable iff (rst_i)
		load_req_i && exe_boot && !tgt_boot && !app[1] |=> load_deny_o)
		else $error("boot load read protected application");

	a_conc_read: assert property (@(posedge clk_i) disable iff (rst_i)
		load_req_i && region_busy_o && !tgt_halt |=> load_deny_o)
		else $error("load from busy concurrent region granted");

	a_irq_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!app[1] && vec_in_boot_i && !exe_boot |-> irq_disable_o)
		else $error("interrupts left on in application code");

	a_boot_read: assert property (@(posedge clk_i) disable iff (rst_i)
		load_req_i && !exe_boot && tgt_boot && !boot[1] |=> load_deny_o)
		else $error("application load read protected boot");

	a_lock_mono: assert property (@(posedge clk_i) disable iff (rst_i)
		!chip_erase_i |=> (r_q.lock & ~$past(r_q.lock)) == 6'h00)
		else $error("lock bit unprogrammed without chip erase");

	a_reset_vec: assert property (@(posedge clk_i) disable iff (rst_i)
		boot_reset_fuse_i |-> reset_vector_o == APP_RESET)
		else $error("reset vector wrong with fuse unprogrammed");

endmodule : spag_guard

/* dv/spag_cpu_model.sv */
/*
 * CPU core and flash array model facing the self-programming access guard.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/10ps
module spag_cpu_model
	import spag_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       flash_start_i,
	output logic            store_req_o,
	output logic      [1:0] store_kind_o,
	output logic      [5:0] store_data_o,
	output logic            load_req_o,
	output logic            flash_done_o
);
	// Flash busy time in cycles; the bench sets it short or long.
	int unsigned dly = 4;
	int unsigned cnt_q;

	initial begin
		store_req_o = 1'b0;
		store_kind_o = OP_LOAD;
		store_data_o = 6'h3F;
		load_req_o = 1'b0;
	end

	// ==========================================================
	// Flash array: one done pulse per started erase or write
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= 0;
			flash_done_o <= 1'b0;
		end else begin
			flash_done_o <= (cnt_q == 1);
			if (flash_start_i)
				cnt_q <= dly;
			else if (cnt_q != 0)
				cnt_q <= cnt_q - 1;
		end
	end

	// ==========================================================
	// Instruction pulses
	// Idle qualifiers are inverted so that a stale value is never used.
	task automatic store_pulse(input logic [1:0] k, input logic [5:0] d);
		store_req_o <= 1'b1;
		store_kind_o <= k;
		store_data_o <= d;
		@(posedge clk_i);
		store_req_o <= 1'b0;
		store_kind_o <= ~k;
		store_data_o <= ~d;
	endtask : store_pulse

	task automatic load_pulse();
		load_req_o <= 1'b1;
		@(posedge clk_i);
		load_req_o <= 1'b0;
	endtask : load_pulse
endmodule : spag_cpu_model

/* dv/spag_guard_tb.sv */
/*
 * Self-checking bench for the self-programming access guard.
 * Assumes the design package and the CPU model are compiled first.
 */
`timescale 1ns/10ps
module spag_guard_tb;
	import spag_pkg::*;
	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic                  cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0]            adr_i = 8'h00;
	logic [3:0]            sel_i = 4'hF;
	logic [31:0]           dat_i = 32'h0, dat_o;
	logic                  ack_o, cpu_stall_o, region_busy_o, irq_disable_o;
	logic                  load_grant_o, load_deny_o, store_refused_o;
	logic                  flash_start_o, byte_select_bit_o;
	logic [15:0]           pc_i = 16'hF100, reset_vector_o;
	logic                  vec_in_boot_i = 1'b0, chip_erase_i = 1'b0;
	logic                  boot_reset_fuse_i = 1'b1;
	logic [1:0]            boot_size_fuses_i = 2'h0, store_kind_i, flash_op_o;
	logic [5:0]            store_data_i;
	logic                  store_req_i, load_req_i, flash_done_i;
	logic [PAGE_W-1:0]     flash_page_o;
	logic [PAGE_IDX_W-1:0] buf_word_o;
	logic [15:0]           bs [4] = '{BOOT_START_0, BOOT_START_1,
		BOOT_START_2, BOOT_START_3};
	int                    n_mismatch = 0, n_tests = 0;

	spag_guard u_spag_guard (.*);
	spag_cpu_model u_spag_cpu_model (.clk_i(clk_i), .rst_i(rst_i),
		.flash_start_i(flash_start_o), .store_req_o(store_req_i),
		.store_kind_o(store_kind_i), .store_data_o(store_data_i),
		.load_req_o(load_req_i), .flash_done_o(flash_done_i));

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic wb(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [31:0] e);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			n_mismatch++;
		if (!w)
			chk(dat_o, e);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic setz(input logic [16:0] z);
		wb(1'b1, OFS_ZLO, {24'h0, z[7:0]}, 32'h0);
		wb(1'b1, OFS_ZHI, {24'h0, z[15:8]}, 32'h0);
		wb(1'b1, OFS_ZEXT, {31'h0, z[16]}, 32'h0);
	endtask : setz

	task automatic finish_op(input logic halt);
		int n;
		n = 0;
		while (flash_done_i !== 1'b1 && n < 200) begin
			chk(cpu_stall_o, halt);
			@(posedge clk_i);
			n++;
		end
		@(posedge clk_i);
		chk(cpu_stall_o, 1'b0);
		chk(region_busy_o, 1'b1);
		wb(1'b1, OFS_CTRL, 32'h2, 32'h0);
		chk(region_busy_o, 1'b0);
	endtask : finish_op

	task automatic store_op(input logic [1:0] k, input logic [16:0] z,
			input logic blk);
		setz(z);
		u_spag_cpu_model.store_pulse(k, 6'h3F);
		@(posedge clk_i);
		chk({store_refused_o, flash_start_o}, {blk, !blk});
		if (blk) begin
			wb(1'b0, OFS_CTRL, 32'h0, 32'h10);
			wb(1'b1, OFS_CTRL, 32'h10, 32'h0);
		end else begin
			chk({flash_op_o, flash_page_o}, {k, z[16:8]});
			finish_op(z >= 17'h1C000);
		end
	endtask : store_op

	task automatic load_op(input logic [16:0] z, input logic blk);
		setz(z);
		u_spag_cpu_model.load_pulse();
		@(posedge clk_i);
		chk({load_grant_o, load_deny_o}, {!blk, blk});
	endtask : load_op

	// Vectors sit in the section that is not executing.
	task automatic lock_case(input logic [5:0] lk, input logic app,
			input logic [16:0] z, input logic ld, input logic blk);
		chip_erase_i <= 1'b1;
		@(posedge clk_i);
		chip_erase_i <= 1'b0;
		pc_i <= 16'hF100;
		u_spag_cpu_model.store_pulse(OP_LOCKSET, lk);
		@(posedge clk_i);
		wb(1'b1, OFS_LOCK, 32'hFF, 32'h0);
		wb(1'b0, OFS_LOCK, 32'h0, {26'h0, lk});
		pc_i <= app ? 16'h0100 : 16'hF100;
		vec_in_boot_i <= app;
		@(posedge clk_i);
		chk(irq_disable_o, app ? !lk[3] : !lk[5]);
		if (ld)
			load_op(z, blk);
		else
			store_op(OP_WRITE, z, blk);
	endtask : lock_case

	// ==========================================================
	// Clock, watchdog and test sequence
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		summarize();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, OFS_CTRL, 32'h0, 32'h0);
		wb(1'b0, OFS_LOCK, 32'h0, 32'h3F);
		wb(1'b1, 8'h18, 32'h5A, 32'h0);
		wb(1'b0, 8'h18, 32'h0, 32'h0);
		setz(17'h1C385);
		wb(1'b0, OFS_ZLO, 32'h0, 32'h85);
		wb(1'b0, OFS_ZHI, 32'h0, 32'hC3);
		wb(1'b0, OFS_ZEXT, 32'h0, 32'h01);
		chk({buf_word_o, byte_select_bit_o}, {7'h42, 1'b1});
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			boot_size_fuses_i <= i[1:0];
			boot_reset_fuse_i <= 1'b0;
			@(posedge clk_i);
			chk(reset_vector_o, bs[i]);
		end
		boot_size_fuses_i <= 2'h0;
		boot_reset_fuse_i <= 1'b1;
		wb(1'b1, OFS_FUSE, 32'h0, 32'h0);
		chk(reset_vector_o, APP_RESET);
		$display("test reset vector done");
		u_spag_cpu_model.dly = 60;
		setz(17'h02000);
		u_spag_cpu_model.store_pulse(OP_ERASE, 6'h3F);
		@(posedge clk_i);
		chk({flash_start_o, flash_op_o}, {1'b1, OP_ERASE});
		chk(flash_page_o, 9'h020);
		u_spag_cpu_model.store_pulse(OP_WRITE, 6'h3F);
		@(posedge clk_i);
		chk(store_refused_o, 1'b1);
		chk({cpu_stall_o, region_busy_o}, 2'h1);
		load_op(17'h1E000, 1'b0);
		chk(flash_page_o, 9'h020);
		load_op(17'h02000, 1'b1);
		wb(1'b0, OFS_CTRL, 32'h0, 32'h15);
		finish_op(1'b0);
		wb(1'b1, OFS_CTRL, 32'h10, 32'h0);
		load_op(17'h02000, 1'b0);
		u_spag_cpu_model.dly = 1;
		store_op(OP_WRITE, 17'h02000, 1'b0);
		$display("test concurrent region done");
		u_spag_cpu_model.dly = 8;
		store_op(OP_ERASE, 17'h1E000, 1'b0);
		store_op(OP_WRITE, 17'h1E000, 1'b0);
		$display("test halting region done");
		u_spag_cpu_model.dly = 3;
		lock_case(6'h3F, 1'b0, 17'h02000, 1'b0, 1'b0);
		lock_case(6'h3B, 1'b0, 17'h02000, 1'b0, 1'b1);
		lock_case(6'h3B, 1'b0, 17'h02000, 1'b1, 1'b0);
		lock_case(6'h33, 1'b0, 17'h02000, 1'b0, 1'b1);
		lock_case(6'h33, 1'b0, 17'h02000, 1'b1, 1'b1);
		lock_case(6'h33, 1'b1, 17'h02000, 1'b1, 1'b0);
		lock_case(6'h37, 1'b0, 17'h02000, 1'b1, 1'b1);
		lock_case(6'h37, 1'b0, 17'h02000, 1'b0, 1'b0);
		lock_case(6'h2F, 1'b0, 17'h1E000, 1'b0, 1'b1);
		lock_case(6'h2F, 1'b1, 17'h1E000, 1'b1, 1'b0);
		lock_case(6'h0F, 1'b1, 17'h1E000, 1'b1, 1'b1);
		lock_case(6'h0F, 1'b0, 17'h1E000, 1'b0, 1'b1);
		lock_case(6'h1F, 1'b1, 17'h1E000, 1'b1, 1'b1);
		lock_case(6'h1F, 1'b0, 17'h1E000, 1'b0, 1'b0);
		lock_case(6'h3E, 1'b0, 17'h02000, 1'b0, 1'b1);
		lock_case(6'h3E, 1'b0, 17'h02000, 1'b1, 1'b0);
		lock_case(6'h3C, 1'b0, 17'h02000, 1'b1, 1'b1);
		lock_case(6'h3C, 1'b0, 17'h02000, 1'b0, 1'b1);
		chip_erase_i <= 1'b1;
		@(posedge clk_i);
		chip_erase_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, OFS_LOCK, 32'h0, 32'h3F);
		$display("test locks done");
		summarize();
	end
endmodule : spag_guard_tb
